// ---- src/adcsr_ctrl.sv ----
// control and serial readout of a four-channel 16-bit sampling converter
// assumes pins arrive asynchronously; CONV_DATA comes from the analog core
// on CLK_SYS and is valid when the conversion time has run out
`timescale 1ns/1ps
`default_nettype none
`include "adcsr_defs.svh"

// Behaviour
// - frame marker is one external serial clock period wide per read
// - frame marker only in external clock mode
// - serial clock driven out in internal mode, input in external mode
// - internal mode: a conversion start while the serial link is idle gives exactly 16 clock periods
// - internal mode: data stable across both clock edges
// - result held in shift register, shifted out MSB first
// - external mode: read previous result during conversion or new after
// - external mode: chip select and read/convert choose the access
// - the two write strobes are ORed into one latch enable
// - address latch transparent while both strobes are low
// - chip select falling with read/convert low starts a conversion
// - chip select falling with read/convert high starts a read
// - busy low from start until result loaded into result register, or until power-down
// - channel address captured by the strobe-controlled latch
// - address 00..11 selects analog inputs 1..4
// - read/convert rising with chip select low enables transmission
// - power-down inhibits conversions and keeps the previous result
// - internal mode pulses carry the preceding conversion result
module adcsr_ctrl #(
  parameter int CONV_CYC = `ADCSR_CONV_CYC,
  parameter int QTR_CYC  = `ADCSR_QTR_CYC
) (
  input  wire logic                     CLK_SYS,
  input  wire logic                     RESET,
  input  wire logic                     CS_N,
  input  wire logic                     READ_CONVERT,
  input  wire logic                     POWER_DOWN_INPUT,
  input  wire logic                     CLOCK_SOURCE_SELECT,
  input  wire logic                     MUX_WRITE_STROBE_A_N,
  input  wire logic                     MUX_WRITE_STROBE_B_N,
  input  wire logic                     CHANNEL_ADDR_HI,
  input  wire logic                     CHANNEL_ADDR_LO,
  input  wire logic [`ADCSR_RES_W-1:0]  CONV_DATA,
  input  wire logic                     SERIAL_CLOCK_I,
  output logic                          SERIAL_CLOCK_O,
  output logic                          SERIAL_CLOCK_OE,
  output logic                          SERIAL_DATA,
  output logic                          FRAME_SYNC,
  output logic                          BUSY_N,
  output logic [3:0]                    ANALOG_INPUT_SEL
);

  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  function automatic adcsr_pkg::adcsr_sel_t dec_sel(
    input adcsr_pkg::adcsr_addr_t a);
    adcsr_pkg::adcsr_sel_t s;
    s = '0;
    s[a] = 1'b1;
    return s;
  endfunction : dec_sel

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; meta_q is read only by syn_q
  // no reset: the chain fills with real pin levels while RESET is held,
  // so a pin idling high gives no false edge at release
  logic [`ADCSR_PIN_W-1:0] meta_q;
  logic [`ADCSR_PIN_W-1:0] syn_q;
  logic [`ADCSR_PIN_W-1:0] prv_q;
  logic [`ADCSR_PIN_W-1:0] pin_v;

  assign pin_v = {CS_N, READ_CONVERT, POWER_DOWN_INPUT, CLOCK_SOURCE_SELECT,
                  MUX_WRITE_STROBE_A_N, MUX_WRITE_STROBE_B_N,
                  CHANNEL_ADDR_HI, CHANNEL_ADDR_LO, SERIAL_CLOCK_I};

  always_ff @(posedge CLK_SYS)
  begin
    meta_q <= pin_v;
    syn_q  <= meta_q;
    prv_q  <= syn_q;
  end

  logic cs_s, rc_s, pd_s, ext_s, wr_or, sk_rise, sk_fall;
  logic cs_prv, rc_prv, conv_go, read_go;
  assign cs_s    = syn_q[8];
  assign rc_s    = syn_q[7];
  assign pd_s    = syn_q[6];
  assign ext_s   = syn_q[5];
  assign cs_prv  = prv_q[8];
  assign rc_prv  = prv_q[7];
  assign wr_or   = syn_q[4] | syn_q[3];
  assign sk_rise = syn_q[0] & ~prv_q[0];
  assign sk_fall = ~syn_q[0] & prv_q[0];
  // chip select and read/convert are ORed, so either may fall last; power-down blocks starts
  assign conv_go = (cs_prv | rc_prv) & ~(cs_s | rc_s)
                   & ~pd_s & BUSY_N;
  assign read_go = (cs_prv & ~cs_s & rc_s)
                 | (~rc_prv & rc_s & ~cs_s);

  //////////////////////////////////////////////////////////////////////////
  // conversion timer, result register and address latch
  logic [15:0]                conv_cnt_q, conv_cnt_d;
  logic                       busy_n_d;
  logic [`ADCSR_RES_W-1:0]    res_q, res_d;
  adcsr_pkg::adcsr_addr_t     addr_q, addr_d;
  adcsr_pkg::adcsr_sel_t      sel_d;

  always_comb
  begin
    conv_cnt_d = conv_cnt_q;
    busy_n_d   = BUSY_N;
    res_d      = res_q;
    addr_d     = addr_q;
    if (conv_go)
    begin
      busy_n_d   = 1'b0;
      conv_cnt_d = 16'(CONV_CYC - 1);
    end
    else if (!BUSY_N)
    begin
      if (pd_s)
        busy_n_d = 1'b1;
      else if (conv_cnt_q == '0)
      begin
        busy_n_d = 1'b1;
        res_d    = CONV_DATA;
      end
      else
        conv_cnt_d = conv_cnt_q - 16'h0001;
    end
    if (!wr_or)
      addr_d = syn_q[2:1];
    sel_d = dec_sel(addr_q);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      conv_cnt_q       <= '0;
      BUSY_N           <= 1'b1;
      res_q            <= '0;
      addr_q           <= `ADCSR_ADDR_RST;
      ANALOG_INPUT_SEL <= `ADCSR_SEL_RST;
    end
    else
    begin
      conv_cnt_q       <= conv_cnt_d;
      BUSY_N           <= busy_n_d;
      res_q            <= res_d;
      addr_q           <= addr_d;
      ANALOG_INPUT_SEL <= sel_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial link: internal clock generator or external clock follower
  adcsr_pkg::adcsr_link_e     st_q, st_d;
  logic [`ADCSR_RES_W-1:0]    sh_q, sh_d;
  logic [3:0]                 bit_q, bit_d;
  logic [1:0]                 ph_q, ph_d;
  logic [15:0]                qtr_q, qtr_d;
  logic                       sclk_d, sync_d;

  always_comb
  begin
    st_d   = st_q;
    sh_d   = sh_q;
    bit_d  = bit_q;
    ph_d   = ph_q;
    qtr_d  = qtr_q;
    sclk_d = SERIAL_CLOCK_O;
    sync_d = FRAME_SYNC;
    unique case (st_q)
      adcsr_pkg::S_IDLE:
      begin
        sclk_d = 1'b0;
        sync_d = 1'b0;
        bit_d  = '0;
        ph_d   = '0;
        qtr_d  = 16'(QTR_CYC - 1);
        // last finished result goes out; a running one is not yet in res_q
        if (!ext_s && conv_go)
        begin
          st_d = adcsr_pkg::S_INT;
          sh_d = res_q;
        end
        else if (ext_s && read_go)
        begin
          st_d = adcsr_pkg::S_ARM;
          sh_d = res_q;
        end
      end
      adcsr_pkg::S_INT:
      begin
        if (qtr_q == '0)
        begin
          qtr_d = 16'(QTR_CYC - 1);
          ph_d  = ph_q + 2'h1;
          // data moves only in the low quarter before each rise
          sclk_d = (ph_d == `ADCSR_PH_RISE) |
                   (ph_d == (`ADCSR_PH_RISE + 2'h1));
          if (ph_q == `ADCSR_LAST_PH)
          begin
            if (bit_q == `ADCSR_LAST_BIT)
              st_d = adcsr_pkg::S_IDLE;
            else
            begin
              bit_d = bit_q + 4'h1;
              sh_d  = {sh_q[`ADCSR_RES_W-2:0], 1'b0};
            end
          end
        end
        else
          qtr_d = qtr_q - 16'h0001;
      end
      adcsr_pkg::S_ARM:
        if (sk_rise)
        begin
          st_d   = adcsr_pkg::S_SYNC;
          sync_d = 1'b1;
        end
      adcsr_pkg::S_SYNC:
        if (sk_rise)
        begin
          st_d   = adcsr_pkg::S_EXT;
          sync_d = 1'b0;
        end
      adcsr_pkg::S_EXT:
        if (sk_fall)
        begin
          if (bit_q == (`ADCSR_LAST_BIT - 4'h1))
            st_d = adcsr_pkg::S_IDLE;
          bit_d = bit_q + 4'h1;
          sh_d  = {sh_q[`ADCSR_RES_W-2:0], 1'b0};
        end
      default:
        st_d = adcsr_pkg::S_IDLE;
    endcase
    // a mode change mid-frame abandons it rather than mixing clocks
    if ((st_q != adcsr_pkg::S_IDLE) &&
        (ext_s != (st_q != adcsr_pkg::S_INT)))
    begin
      st_d   = adcsr_pkg::S_IDLE;
      sclk_d = 1'b0;
      sync_d = 1'b0;
    end
    if (!ext_s)
      sync_d = 1'b0;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      st_q            <= adcsr_pkg::S_IDLE;
      sh_q            <= '0;
      bit_q           <= '0;
      ph_q            <= '0;
      qtr_q           <= '0;
      SERIAL_CLOCK_O  <= 1'b0;
      SERIAL_CLOCK_OE <= 1'b0;
      FRAME_SYNC      <= 1'b0;
      SERIAL_DATA     <= 1'b0;
    end
    else
    begin
      st_q            <= st_d;
      sh_q            <= sh_d;
      bit_q           <= bit_d;
      ph_q            <= ph_d;
      qtr_q           <= qtr_d;
      SERIAL_CLOCK_O  <= sclk_d & ~ext_s;
      SERIAL_CLOCK_OE <= ~ext_s;
      FRAME_SYNC      <= sync_d;
      SERIAL_DATA     <= sh_d[`ADCSR_RES_W-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  logic [4:0] rise_cnt_q;
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET || st_q != adcsr_pkg::S_INT)
      rise_cnt_q <= '0;
    else if (sclk_d & ~SERIAL_CLOCK_O)
      rise_cnt_q <= rise_cnt_q + 5'h01;
  end

  AST_SYNC_EDGE: assert property (
    $changed(FRAME_SYNC) && ext_s |-> $past(sk_rise))
    else $error("frame marker moved off a serial clock rise");
  AST_SYNC_MODE: assert property (FRAME_SYNC |-> $past(ext_s))
    else $error("frame marker in internal clock mode");
  AST_OE_MODE: assert property (
    $past(ext_s) |-> !SERIAL_CLOCK_OE && !SERIAL_CLOCK_O)
    else $error("serial clock driven in external mode");
  AST_SIXTEEN: assert property (
    st_q == adcsr_pkg::S_INT && st_d == adcsr_pkg::S_IDLE && !ext_s
    |-> rise_cnt_q == 5'h10)
    else $error("internal frame without sixteen clock periods");
  AST_DATA_STABLE: assert property (
    st_q == adcsr_pkg::S_INT && SERIAL_CLOCK_O
    && $past(SERIAL_CLOCK_O) |-> $stable(SERIAL_DATA))
    else $error("data moved while serial clock high");
  AST_BUSY_LOAD: assert property (
    $rose(BUSY_N) && !$past(pd_s) |-> res_q == $past(CONV_DATA))
    else $error("busy released without result load");
  AST_CONV_START: assert property (
    conv_go |=> !BUSY_N ##1 (!BUSY_N || $past(pd_s)))
    else $error("conversion start did not drop busy");
  AST_POWER_DOWN_INPUT_HOLD: assert property (pd_s |=> $stable(res_q))
    else $error("result changed in power-down");
  AST_LATCH_HOLD: assert property (wr_or |=> $stable(addr_q))
    else $error("address latch moved while strobe high");
  AST_CHAN_SEL: assert property (
    ##1 ANALOG_INPUT_SEL == (`ADCSR_SEL_RST << $past(addr_q)))
    else $error("channel select does not follow address");
  AST_INT_LOAD: assert property (
    st_q == adcsr_pkg::S_IDLE && !ext_s && conv_go
    |=> sh_q == $past(res_q))
    else $error("internal frame not loaded with prior result");

  COV_INT_FRAME: cover property (
    st_q == adcsr_pkg::S_INT ##1 st_q == adcsr_pkg::S_IDLE);
  COV_EXT_FRAME: cover property (
    st_q == adcsr_pkg::S_EXT ##1 st_q == adcsr_pkg::S_IDLE);
  COV_CONV_DONE: cover property ($rose(BUSY_N));
  COV_READ_BUSY: cover property (
    !BUSY_N && st_q == adcsr_pkg::S_SYNC);

endmodule : adcsr_ctrl
`default_nettype wire

// ---- src/adcsr_defs.svh ----
// timing, width and reset constants of the converter readout control
// assumes a 200 MHz system clock; included by bare name
`ifndef ADCSR_DEFS_SVH
`define ADCSR_DEFS_SVH
`define ADCSR_RES_W      16
`define ADCSR_CLK_PS     5000
`define ADCSR_CONV_NS    4000
`define ADCSR_CONV_CYC   ((`ADCSR_CONV_NS*1000+`ADCSR_CLK_PS-1)/`ADCSR_CLK_PS)
`define ADCSR_QTR_NS     50
`define ADCSR_QTR_CYC    ((`ADCSR_QTR_NS*1000)/`ADCSR_CLK_PS)
`define ADCSR_LAST_BIT   4'hF
`define ADCSR_LAST_PH    2'h3
`define ADCSR_PH_RISE    2'h1
`define ADCSR_PH_FALL    2'h3
`define ADCSR_ADDR_RST   2'h0
`define ADCSR_SEL_RST    4'h1
`define ADCSR_PIN_W      9
`endif

// ---- src/adcsr_pkg.sv ----
// types shared by the converter readout control
// no surroundings assumed
package adcsr_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_INT  = 5'h02,
    S_ARM  = 5'h04,
    S_SYNC = 5'h08,
    S_EXT  = 5'h10
  } adcsr_link_e;
  typedef logic [1:0] adcsr_addr_t;
  typedef logic [3:0] adcsr_sel_t;
endpackage : adcsr_pkg

// ---- test/adcsr_host_model.sv ----
// host partner: external serial clock source and serial word receiver
// assumes the bench drives chip select and read/convert itself
`timescale 1ns/1ps
`default_nettype none
module adcsr_host_model (
  input  wire logic        serial_clock_o,
  input  wire logic        serial_data,
  input  wire logic        frame_sync,
  output logic             serial_clock_i,
  output logic [15:0]      word_r,
  output logic [15:0]      word_f,
  output logic [4:0]       frame_cnt,
  output logic [4:0]       rise_cnt,
  output logic             done
);
  initial
  begin
    serial_clock_i = 1'b0;
    rise_cnt = 5'h00;
    frame_cnt = 5'h00;
    done = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // internal mode: latch on both edges so unstable bits show up
  always @(posedge serial_clock_o)
  begin
    word_r = {word_r[14:0], serial_data};
    rise_cnt = rise_cnt + 5'h01;
    if (rise_cnt == 5'h10)
    begin
      rise_cnt = 5'h00;
      @(negedge serial_clock_o);
      #2;
      done = 1'b1;
      #1;
      done = 1'b0;
    end
  end
  always @(negedge serial_clock_o)
    word_f = {word_f[14:0], serial_data};
  ////////////////////////////////////////////////////////////////////////
  // external mode: 17 rises, the first carries the frame marker only;
  // clock stands low between frames
  task automatic read_frame();
    int i;
    frame_cnt = 5'h00;
    for (i = 0; i < 17; i++)
    begin
      serial_clock_i = 1'b1;
      if (i > 0)
        word_r = {word_r[14:0], serial_data};
      #62.5;
      if (frame_sync === 1'b1)
        frame_cnt = frame_cnt + 5'h01;
      serial_clock_i = 1'b0;
      #62.5;
    end
    word_f = word_r;
    done = 1'b1;
    #1;
    done = 1'b0;
  endtask : read_frame
endmodule : adcsr_host_model
`default_nettype wire

// ---- test/test_adc_serial_readout_mux_ctrl.sv ----
// self-checking bench of the converter readout control
// assumes the host partner model; small conversion and phase counts
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_readout_mux_ctrl;
  logic        clk_sys, reset, cs_n, rd_cv, pwr_dn, clk_src, done;
  logic        wr_a_n, wr_b_n, sclk_i, sclk_o, sclk_oe, sdata, fsync, busy_n;
  logic [1:0]  addr;
  logic [3:0]  sel;
  logic [4:0]  frame_cnt, rise_cnt;
  logic [15:0] conv_data, word_r, word_f, e, prev, d;
  logic [15:0] exp_q[$];
  int          err_count, checked;
  logic [31:0] rs;
  adcsr_ctrl #(.CONV_CYC(20), .QTR_CYC(2)) i_dut (
    .CLK_SYS(clk_sys), .RESET(reset), .CS_N(cs_n), .READ_CONVERT(rd_cv),
    .POWER_DOWN_INPUT(pwr_dn), .CLOCK_SOURCE_SELECT(clk_src),
    .MUX_WRITE_STROBE_A_N(wr_a_n), .MUX_WRITE_STROBE_B_N(wr_b_n),
    .CHANNEL_ADDR_HI(addr[1]), .CHANNEL_ADDR_LO(addr[0]),
    .CONV_DATA(conv_data), .SERIAL_CLOCK_I(sclk_i),
    .SERIAL_CLOCK_O(sclk_o), .SERIAL_CLOCK_OE(sclk_oe),
    .SERIAL_DATA(sdata), .FRAME_SYNC(fsync), .BUSY_N(busy_n),
    .ANALOG_INPUT_SEL(sel));
  adcsr_host_model i_host (
    .serial_clock_o(sclk_o), .serial_data(sdata), .frame_sync(fsync),
    .serial_clock_i(sclk_i), .word_r(word_r), .word_f(word_f),
    .frame_cnt(frame_cnt), .rise_cnt(rise_cnt), .done(done));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[15:0];
  endfunction : rnd
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic cmp_word(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value at %0t: word %h not %h", $time, g, x);
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic g, input logic x);
    checked++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value at %0t: flag %b not %b", $time, g, x);
    end
  endtask : cmp_flag
  task automatic cmp_sel(input logic [3:0] g, input logic [3:0] x);
    checked++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value at %0t: select %h not %h", $time, g, x);
    end
  endtask : cmp_sel
  // chip select pulsed low while read/convert is low
  task automatic start(input logic xb);
    rd_cv = 1'b0;
    tick(1);
    cs_n = 1'b0;
    tick(4);
    cs_n = 1'b1;
    tick(2);
    rd_cv = 1'b1;
    cmp_flag(busy_n, xb);
  endtask : start
  task automatic wait_busy();
    int n;
    n = 0;
    while (busy_n !== 1'b1 && n < 60)
    begin
      tick(1);
      n++;
    end
    cmp_flag(busy_n, 1'b1);
  endtask : wait_busy
  task automatic ext_read();
    cs_n = 1'b0;
    tick(4);
    i_host.read_frame();
    cs_n = 1'b1;
    tick(4);
    cmp_word({11'h000, frame_cnt}, 16'h0001);
  endtask : ext_read
  ////////////////////////////////////////////////////////////////////////
  always @(posedge done)
  begin
    if (exp_q.size() == 0)
      cmp_flag(1'b1, 1'b0);
    else
    begin
      e = exp_q.pop_front();
      cmp_word(word_r, e);
      cmp_word(word_f, e);
    end
  end
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100000;
    err_count++;
    summarize();
  end
  initial
  begin
    {reset, cs_n, rd_cv, wr_a_n, wr_b_n} = 5'h1F;
    {pwr_dn, clk_src, addr, conv_data} = 20'h00000;
    err_count = 0;
    checked = 0;
    rs = 32'h00002AE2;
    prev = 16'h0000;
    tick(3);
    reset = 1'b0;
    tick(3);
    cmp_flag(busy_n, 1'b1);
    cmp_sel(sel, 4'h1);
    cmp_flag(sclk_oe, 1'b1);
    for (int a = 0; a < 4; a++)
    begin
      {wr_a_n, wr_b_n} = 2'h0;
      addr = a[1:0];
      tick(6);
      cmp_sel(sel, 4'h1 << a);
      if (a[0])
        wr_a_n = 1'b1;
      else
        wr_b_n = 1'b1;
      tick(1);
      addr = ~a[1:0];
      tick(6);
      cmp_sel(sel, 4'h1 << a);
    end
    for (int k = 0; k < 3; k++)
    begin
      d = rnd();
      exp_q.push_back(prev);
      conv_data = d;
      start(1'b0);
      wait_busy();
      prev = d;
      tick(150);
      cmp_flag(fsync, 1'b0);
    end
    cmp_word({11'h000, rise_cnt}, 16'h0000);
    clk_src = 1'b1;
    tick(6);
    cmp_flag(sclk_oe, 1'b0);
    d = rnd();
    conv_data = d;
    start(1'b0);
    wait_busy();
    exp_q.push_back(d);
    ext_read();
    prev = d;
    exp_q.push_back(prev);
    conv_data = rnd();
    rd_cv = 1'b0;
    cs_n = 1'b0;
    tick(4);
    rd_cv = 1'b1;
    tick(4);
    cmp_flag(busy_n, 1'b0);
    i_host.read_frame();
    cs_n = 1'b1;
    prev = conv_data;
    tick(10);
    pwr_dn = 1'b1;
    conv_data = rnd();
    start(1'b1);
    tick(20);
    pwr_dn = 1'b0;
    exp_q.push_back(prev);
    ext_read();
    tick(10);
    cmp_word({15'h0000, exp_q.size() == 0}, 16'h0001);
    summarize();
  end
endmodule : test_adc_serial_readout_mux_ctrl
`default_nettype wire
